// ### ddp_pkg.sv
// Package with register map, reset values and divider table for the dimming generator
// Function
// - Divider select codes 0..7 divide oscillator by 7,8,10,12,16,24,49,98.
// - Dimming counter clock derives from the 10.8 MHz oscillator via the selected ratio.
// - Divider register resets to 0x04 (divide by 16); upper five bits reserved.
// - Address 0x0D holds channel 1 width bits 7..0, fully read/write.
// - Address 0x0E holds channel 1 width bits 9..8; bits 7..2 read zero.
// - Address 0x0F holds channel 2 width bits 7..0, fully read/write.
// - Address 0x10 holds channel 2 width bits 9..8; bits 7..2 read zero.
// - All four width registers reset to 0x00.
// - Address 0x11 holds channel 1 six-bit on-time code, reset 0x07, bits 7..6 zero.
// - Address 0x12 holds channel 2 six-bit on-time code, reset 0x07, bits 7..6 zero.
`default_nettype none
package ddp_pkg;
  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DIV      = 8'h0C;
  localparam logic [7:0] ADDR_CH1_LOW  = 8'h0D;
  localparam logic [7:0] ADDR_CH1_HIGH = 8'h0E;
  localparam logic [7:0] ADDR_CH2_LOW  = 8'h0F;
  localparam logic [7:0] ADDR_CH2_HIGH = 8'h10;
  localparam logic [7:0] ADDR_CH1_TON  = 8'h11;
  localparam logic [7:0] ADDR_CH2_TON  = 8'h12;
  // ----------------------------------------------------------------
  // Field widths and reset values
  // ----------------------------------------------------------------
  localparam int         DIV_W      = 3;
  localparam int         HIGH_W     = 2;
  localparam int         TON_W      = 6;
  localparam int         WIDTH_W    = 10;
  localparam logic [2:0] DIV_RST    = 3'h4;
  localparam logic [7:0] WIDTH_RST  = 8'h00;
  localparam logic [5:0] TON_RST    = 6'h07;
  localparam logic [1:0] HIGH_RST   = 2'h0;
  localparam logic [7:0] READ_ZERO  = 8'h00;
  // ----------------------------------------------------------------
  // Clock figures
  // ----------------------------------------------------------------
  localparam int OSC_KHZ = 10800;
  localparam int CLK_W   = 7;
  // Divide ratio table, minus one for a terminal count
  function automatic logic [6:0] div_term(input logic [2:0] sel);
    logic [6:0] r;
    r = 7'h00;
    unique case (sel)
      3'h0: r = 7'h06;
      3'h1: r = 7'h07;
      3'h2: r = 7'h09;
      3'h3: r = 7'h0B;
      3'h4: r = 7'h0F;
      3'h5: r = 7'h17;
      3'h6: r = 7'h30;
      3'h7: r = 7'h61;
    endcase
    return r;
  endfunction
endpackage
`default_nettype wire

// ### ddp_chan.sv
// One dimming output comparator
`timescale 1ns/10ps
`default_nettype none
module ddp_chan #(
  parameter int W = 10
) (
  input  wire logic         clk_sys_in,
  input  wire logic         nrst_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] count_in,
  input  wire logic [W-1:0] width_in,
  output logic              dim_out
);
  wire logic on_w = (count_in < width_in);
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      dim_out <= 1'b0;
    end else if (ce_in) begin
      dim_out <= on_w;
    end
  end
endmodule
`default_nettype wire

// ### ddp_top.sv
// Register file, oscillator divider and counter of the dual dimming generator
`timescale 1ns/10ps
`default_nettype none
module ddp_top #(
  parameter int WIDTH_W = ddp_pkg::WIDTH_W
) (
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  input  wire logic        ce_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic      [7:0]  reg_rdata_out,
  output logic             ch1_dim_out,
  output logic             ch2_dim_out,
  output logic [5:0]       ch1_on_time_code_out,
  output logic [5:0]       ch2_on_time_code_out
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [2:0] dim_clock_divider_sel_q;
  logic [7:0] ch1_dim_width_low_q;
  logic [1:0] ch1_dim_width_high_q;
  logic [7:0] ch2_dim_width_low_q;
  logic [1:0] ch2_dim_width_high_q;
  logic [6:0] pre_q;
  logic [WIDTH_W-1:0] count_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // ce_in gates the strobes, so a frozen block ignores the bus as well
  // Unmapped addresses match no strobe: writes there drop, reads give zero
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    return (addr == target);
  endfunction

  wire logic wr_en_w   = ce_in && reg_wr_in;
  wire logic rd_en_w   = ce_in && reg_rd_in;

  wire logic sel_div_w = addr_hit(reg_addr_in, ddp_pkg::ADDR_DIV);
  wire logic sel_c1l_w = addr_hit(reg_addr_in, ddp_pkg::ADDR_CH1_LOW);
  wire logic sel_c1h_w = addr_hit(reg_addr_in, ddp_pkg::ADDR_CH1_HIGH);
  wire logic sel_c2l_w = addr_hit(reg_addr_in, ddp_pkg::ADDR_CH2_LOW);
  wire logic sel_c2h_w = addr_hit(reg_addr_in, ddp_pkg::ADDR_CH2_HIGH);
  wire logic sel_t1_w  = addr_hit(reg_addr_in, ddp_pkg::ADDR_CH1_TON);
  wire logic sel_t2_w  = addr_hit(reg_addr_in, ddp_pkg::ADDR_CH2_TON);

  wire logic wr_div_w  = wr_en_w && sel_div_w;
  wire logic wr_c1l_w  = wr_en_w && sel_c1l_w;
  wire logic wr_c1h_w  = wr_en_w && sel_c1h_w;
  wire logic wr_c2l_w  = wr_en_w && sel_c2l_w;
  wire logic wr_c2h_w  = wr_en_w && sel_c2h_w;
  wire logic wr_t1_w   = wr_en_w && sel_t1_w;
  wire logic wr_t2_w   = wr_en_w && sel_t2_w;

  // ----------------------------------------------------------------
  // Write data fields; reserved bits are dropped on the way in
  // ----------------------------------------------------------------
  wire logic [ddp_pkg::DIV_W-1:0]  wdata_div_w  = reg_wdata_in[ddp_pkg::DIV_W-1:0];
  wire logic [ddp_pkg::HIGH_W-1:0] wdata_high_w = reg_wdata_in[ddp_pkg::HIGH_W-1:0];
  wire logic [ddp_pkg::TON_W-1:0]  wdata_ton_w  = reg_wdata_in[ddp_pkg::TON_W-1:0];

  // ----------------------------------------------------------------
  // Divider select
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      dim_clock_divider_sel_q <= ddp_pkg::DIV_RST;
    end else if (wr_div_w) begin
      dim_clock_divider_sel_q <= wdata_div_w;
    end
  end

  // ----------------------------------------------------------------
  // Channel 1 width; the two bytes land independently, no staging latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ch1_dim_width_low_q <= ddp_pkg::WIDTH_RST;
    end else if (wr_c1l_w) begin
      ch1_dim_width_low_q <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ch1_dim_width_high_q <= ddp_pkg::HIGH_RST;
    end else if (wr_c1h_w) begin
      ch1_dim_width_high_q <= wdata_high_w;
    end
  end

  // ----------------------------------------------------------------
  // Channel 2 width
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ch2_dim_width_low_q <= ddp_pkg::WIDTH_RST;
    end else if (wr_c2l_w) begin
      ch2_dim_width_low_q <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ch2_dim_width_high_q <= ddp_pkg::HIGH_RST;
    end else if (wr_c2h_w) begin
      ch2_dim_width_high_q <= wdata_high_w;
    end
  end

  // ----------------------------------------------------------------
  // On-time codes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ch1_on_time_code_out <= ddp_pkg::TON_RST;
    end else if (wr_t1_w) begin
      ch1_on_time_code_out <= wdata_ton_w;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ch2_on_time_code_out <= ddp_pkg::TON_RST;
    end else if (wr_t2_w) begin
      ch2_on_time_code_out <= wdata_ton_w;
    end
  end

  // ----------------------------------------------------------------
  // Read data; reserved bits and unmapped addresses read zero
  // ----------------------------------------------------------------
  wire logic [7:0] rd_div_w = 8'(dim_clock_divider_sel_q);
  wire logic [7:0] rd_c1l_w = ch1_dim_width_low_q;
  wire logic [7:0] rd_c1h_w = 8'(ch1_dim_width_high_q);
  wire logic [7:0] rd_c2l_w = ch2_dim_width_low_q;
  wire logic [7:0] rd_c2h_w = 8'(ch2_dim_width_high_q);
  wire logic [7:0] rd_t1_w  = 8'(ch1_on_time_code_out);
  wire logic [7:0] rd_t2_w  = 8'(ch2_on_time_code_out);

  wire logic [7:0] rd_sel_w = sel_div_w ? rd_div_w :
                              sel_c1l_w ? rd_c1l_w :
                              sel_c1h_w ? rd_c1h_w :
                              sel_c2l_w ? rd_c2l_w :
                              sel_c2h_w ? rd_c2h_w :
                              sel_t1_w  ? rd_t1_w  :
                              sel_t2_w  ? rd_t2_w  :
                              ddp_pkg::READ_ZERO;

  // Read data holds until the next read strobe
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= ddp_pkg::READ_ZERO;
    end else if (rd_en_w) begin
      reg_rdata_out <= rd_sel_w;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator prescaler
  // ----------------------------------------------------------------
  // clk_sys_in stands in for the internal oscillator. A new divider select
  // applies at once; if the prescaler is already past the new terminal
  // count the next edge ticks, so one period may come out short.
  wire logic [6:0] term_w = ddp_pkg::div_term(dim_clock_divider_sel_q);
  wire logic       tick_w = (pre_q >= term_w);
  wire logic [6:0] pre_d  = tick_w ? 7'h00 : pre_q + 7'h01;

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      pre_q <= '0;
    end else if (ce_in) begin
      pre_q <= pre_d;
    end
  end

  // ----------------------------------------------------------------
  // Dimming counter
  // ----------------------------------------------------------------
  // Plain binary wrap of a WIDTH_W-bit count gives the 1024-count period
  wire logic [WIDTH_W-1:0] count_d = count_q + WIDTH_W'(1);

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      count_q <= '0;
    end else if (ce_in && tick_w) begin
      count_q <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // Channel 1 output
  // ----------------------------------------------------------------
  wire logic [WIDTH_W-1:0] w1_w = {ch1_dim_width_high_q, ch1_dim_width_low_q};

  ddp_chan #(.W(WIDTH_W)) u_ch1 (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .ce_in      (ce_in),
    .count_in   (count_q),
    .width_in   (w1_w),
    .dim_out    (ch1_dim_out)
  );

  // ----------------------------------------------------------------
  // Channel 2 output
  // ----------------------------------------------------------------
  wire logic [WIDTH_W-1:0] w2_w = {ch2_dim_width_high_q, ch2_dim_width_low_q};

  ddp_chan #(.W(WIDTH_W)) u_ch2 (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .ce_in      (ce_in),
    .count_in   (count_q),
    .width_in   (w2_w),
    .dim_out    (ch2_dim_out)
  );
endmodule
`default_nettype wire

// ### ddp_monitor.sv
// Port checker for the dual dimming generator
`timescale 1ns/10ps
`default_nettype none
module ddp_monitor (
  input wire logic       clk_sys_in,
  input wire logic       nrst_in,
  input wire logic       ce_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       ch1_dim_out,
  input wire logic       ch2_dim_out,
  input wire logic [5:0] ch1_on_time_code_out,
  input wire logic [5:0] ch2_on_time_code_out
);
  wire logic       rd = ce_in && reg_rd_in;
  wire logic       w1 = ce_in && reg_wr_in && reg_addr_in == 8'h11;
  wire logic       w2 = ce_in && reg_wr_in && reg_addr_in == 8'h12;
  wire logic [5:0] wd = reg_wdata_in[5:0];
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);
  // Reset checks cannot be disabled by the reset they check
  ton_rst_a: assert property (disable iff (1'b0) !nrst_in |=>
    ch1_on_time_code_out == 6'h07 && ch2_on_time_code_out == 6'h07) else $error("ton reset");
  dim_rst_a: assert property (disable iff (1'b0) !nrst_in |=>
    !ch1_dim_out && !ch2_dim_out) else $error("dim reset");
  ton1_wr_a: assert property (w1 |=> ch1_on_time_code_out == $past(wd))
    else $error("ton1 write");
  ton2_wr_a: assert property (w2 |=> ch2_on_time_code_out == $past(wd))
    else $error("ton2 write");
  ton_hold_a: assert property (!w1 && !w2 |=> $stable(ch1_on_time_code_out)
    && $stable(ch2_on_time_code_out)) else $error("ton changed");
  high_res_a: assert property (rd && reg_addr_in inside {8'h0E, 8'h10} |=>
    reg_rdata_out[7:2] == 6'h00) else $error("high reserved");
  ton_rd_a: assert property (rd && reg_addr_in == 8'h11 |=>
    reg_rdata_out == {2'h0, $past(ch1_on_time_code_out)}) else $error("ton1 read");
  div_rd_a: assert property (rd && reg_addr_in == 8'h0C |=> reg_rdata_out[7:3] == 5'h00)
    else $error("div reserved");
  cover property (w1);
  cover property (rd && reg_addr_in == 8'h0C);
  cover property ($rose(ch1_dim_out));
endmodule
bind ddp_top ddp_monitor mon_u (.clk_sys_in, .nrst_in, .ce_in, .reg_wr_in, .reg_rd_in,
  .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .ch1_dim_out, .ch2_dim_out,
  .ch1_on_time_code_out, .ch2_on_time_code_out);
`default_nettype wire

// ### ddp_host.sv
// Parallel bus host model that issues register requests
`timescale 1ns/10ps
`default_nettype none
module ddp_host (
  input  wire logic       clk_sys_in,
  input  wire logic [7:0] reg_rdata_in,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  output logic      [7:0] reg_addr_out,
  output logic      [7:0] reg_wdata_out
);
  initial begin
    {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out} = 18'h0;
  end
  // Released address and data lines go inverted and the strobes drop to zero, so a stale value never looks valid
  task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge clk_sys_in);
    {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out} = {w, !w, a, d};
    @(negedge clk_sys_in);
    q = reg_rdata_in;
    {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out} = {2'h0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// ### dual_dimming_pwm_config_tb.sv
// Register and dimming test of the dual dimming generator
`timescale 1ns/10ps
`default_nettype none
module dual_dimming_pwm_config_tb;
  logic       clk_sys_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic       ce_in = 1'b1;
  logic       wr, rd, d1, d2;
  logic [7:0] addr, wdata, rdata, q;
  logic [5:0] t1, t2;
  int         fails = 0;
  int         n_tests = 0;
  int         cyc = 0;
  int         n;
  localparam logic [7:0] AD [7] = '{8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12};
  localparam logic [7:0] RS [7] = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h07};
  localparam logic [7:0] MK [7] = '{8'h07, 8'hFF, 8'h03, 8'hFF, 8'h03, 8'h3F, 8'h3F};
  localparam logic [7:0] RT [8] = '{8'h07, 8'h08, 8'h0A, 8'h0C, 8'h10, 8'h18, 8'h31, 8'h62};
  always #20 clk_sys_in = ~clk_sys_in;
  ddp_host host_u (.clk_sys_in, .reg_rdata_in(rdata), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_addr_out(addr), .reg_wdata_out(wdata));
  ddp_top dut_u (.clk_sys_in, .nrst_in, .ce_in, .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .ch1_dim_out(d1),
    .ch2_dim_out(d2), .ch1_on_time_code_out(t1), .ch2_on_time_code_out(t2));
  task automatic chk(input string nm, input logic [7:0] e, s);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrt(input logic [7:0] a, d);
    host_u.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, e);
    host_u.xfer(1'b0, a, 8'h00, q);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic test_done();
    if (fails == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Ratio test needs about 33 counts of every divide ratio
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    repeat (6) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    for (int i = 0; i < 7; i++) rdc(AD[i], RS[i]);
    for (int i = 0; i < 7; i++) wrt(AD[i], 8'hFF);
    for (int i = 0; i < 7; i++) rdc(AD[i], MK[i]);
    chk("ton1 pins", 8'h3F, {2'h0, t1});
    chk("ton2 pins", 8'h3F, {2'h0, t2});
    ce_in = 1'b0;
    wrt(8'h0D, 8'h5A);
    ce_in = 1'b1;
    rdc(8'h0D, 8'hFF);
    // Fall spacing of two widths one count apart equals the divide ratio
    for (int c = 0; c < 8; c++) begin
      nrst_in = 1'b0;
      @(negedge clk_sys_in);
      nrst_in = 1'b1;
      wrt(8'h0C, 8'(c));
      wrt(8'h0D, 8'h20);
      wrt(8'h0F, 8'h21);
      n = 0;
      while (d1 !== 1'b1) @(negedge clk_sys_in);
      while (d1 !== 1'b0) @(negedge clk_sys_in);
      while (d2 === 1'b1) begin
        n++;
        @(negedge clk_sys_in);
      end
      chk("ratio", RT[c], n[7:0]);
    end
    test_done();
  end
endmodule
`default_nettype wire
